// ---- rtl/aftl_pkg.sv ----
package aftl_pkg;
    // bus geometry
    localparam int unsigned AW             = 10;
    localparam int unsigned DW             = 32;
    localparam int unsigned NCH            = 3;
    // register indices, byte address is four times the index
    localparam logic [7:0]  IDX_OP0        = 8'h33;
    localparam logic [7:0]  IDX_CTRL1      = 8'h36;
    localparam logic [7:0]  IDX_CTRL2      = 8'h37;
    localparam logic [7:0]  IDX_LO0        = 8'h4e;
    localparam logic [7:0]  IDX_HI0        = 8'h4f;
    localparam logic [7:0]  IDX_FS0        = 8'h70;
    localparam logic [7:0]  IDX_CFG        = 8'h73;
    localparam logic [7:0]  IDX_HY0        = 8'h74;
    localparam logic [7:0]  IDX_STAT       = 8'h77;
    // reset values
    localparam logic [7:0]  RST_OP         = 8'ha4;
    localparam logic [7:0]  RST_LO         = 8'h01;
    localparam logic [7:0]  RST_HI         = 8'h7f;
    localparam logic [7:0]  RST_FS         = 8'h5a;
    localparam logic [7:0]  RST_HY         = 8'h04;
    localparam logic [7:0]  RST_CTRL1      = 8'h00;
    localparam logic [7:0]  RST_CTRL2      = 8'h00;
    localparam logic [7:0]  RST_CFG        = 8'h00;
    // field positions
    localparam int unsigned CTRL1_CYB_MSB  = 0;
    localparam int unsigned CTRL1_CAP_LSB  = 2;
    localparam int unsigned CTRL1_ADP_LSB  = 5;
    localparam int unsigned CTRL2_CYA_LSB  = 0;
    localparam int unsigned CTRL2_CYL_LSB  = 3;
    localparam int unsigned CTRL2_CYB_LSB  = 6;
    localparam int unsigned CFG_OFS64_BIT  = 0;
    localparam int unsigned CFG_SMOOTH_BIT = 1;
    localparam int unsigned HY_W           = 5;
    localparam int unsigned STAT_HOT_BIT   = 3;
    // loop constants
    localparam logic [11:0] SHORT_BASE     = 12'h008;
    localparam logic signed [9:0]  OFS64   = 10'sd64;
    localparam logic signed [11:0] FLOOR_TWOS = -12'sd127;
    localparam logic signed [11:0] FLOOR_OFS  = -12'sd64;
    localparam logic signed [11:0] SLOW_RISE_Q = 12'sd1;
endpackage : aftl_pkg

// ---- rtl/aftl_top.sv ----
`timescale 1ns/1ns
module aftl_top
    import aftl_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [aftl_pkg::AW-1:0] paddr,
    input  wire logic [aftl_pkg::DW-1:0] pwdata,
    output logic      [aftl_pkg::DW-1:0] prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [9:0]           temp_remote_a,
    input  wire logic [9:0]           temp_local,
    input  wire logic [9:0]           temp_remote_b,
    input  wire logic                 monitor_done,
    input  wire logic                 overheat_flag_in_n,
    output logic      [7:0]           fan_start_remote_a,
    output logic      [7:0]           fan_start_local,
    output logic      [7:0]           fan_start_remote_b,
    output logic      [2:0]           fan_off
);
    import aftl_pkg::*;

    function automatic logic signed [9:0] deg(input logic [7:0] r,
                                              input logic       ofs);
        deg = ofs ? ($signed({2'b00, r}) - OFS64) : {{2{r[7]}}, r};
    endfunction : deg

    logic [7:0]             ctrl1;
    logic [7:0]             ctrl2;
    logic [7:0]             cfg;
    logic [7:0]             op     [NCH];
    logic [7:0]             lo     [NCH];
    logic [7:0]             hi     [NCH];
    logic [7:0]             fs     [NCH];
    logic [HY_W-1:0]        hy     [NCH];
    logic [7:0]             fs_out [NCH];
    logic [11:0]            cnt    [NCH];
    logic [9:0]             prev_t [NCH];
    logic                   hot_s1;
    logic                   hot_s2;
    logic                   hot_s3;

    wire  [9:0]             temp   [NCH];
    wire  [2:0]             cyc_sel[NCH];
    wire  [7:0]             rd_ch  [NCH];
    wire  [NCH-1:0]         hit_ch;
    wire  [NCH-1:0]         wr_op;
    wire  [NCH-1:0]         wr_lo;
    wire  [NCH-1:0]         wr_hi;
    wire  [NCH-1:0]         wr_fs;
    wire  [NCH-1:0]         wr_hy;

    assign temp[0] = temp_remote_a;
    assign temp[1] = temp_local;
    assign temp[2] = temp_remote_b;
    assign fan_start_remote_a = fs_out[0];
    assign fan_start_local    = fs_out[1];
    assign fan_start_remote_b = fs_out[2];

    // cycle selects per channel
    assign cyc_sel[0] = ctrl2[CTRL2_CYA_LSB +: 3];
    assign cyc_sel[1] = ctrl2[CTRL2_CYL_LSB +: 3];
    assign cyc_sel[2] = {ctrl1[CTRL1_CYB_MSB],
                         ctrl2[CTRL2_CYB_LSB +: 2]};

    // apb decode
    wire       acc     = psel & penable & ~pready;
    wire       commit  = psel & penable & pready;
    wire [7:0] idx     = paddr[AW-1:2];
    wire       aligned = (paddr[1:0] == 2'b00);
    wire       wr_en   = commit & pwrite & aligned;
    wire       ofs     = cfg[CFG_OFS64_BIT];
    wire       smooth  = cfg[CFG_SMOOTH_BIT];
    wire       hit_c1  = (idx == IDX_CTRL1);
    wire       hit_c2  = (idx == IDX_CTRL2);
    wire       hit_cfg = (idx == IDX_CFG);
    wire       hit_st  = (idx == IDX_STAT);
    wire       hit_any = aligned & (hit_c1 | hit_c2 | hit_cfg | hit_st
                                    | (|hit_ch));
    wire [7:0] stat    = {4'h0, ~hot_s2, fan_off}
                         | 8'h00;
    wire [7:0] rd_glb  = hit_c1  ? ctrl1 :
                         hit_c2  ? ctrl2 :
                         hit_cfg ? cfg   :
                         hit_st  ? stat  : 8'h00;
    wire [7:0] rd_all  = rd_glb | rd_ch[0] | rd_ch[1] | rd_ch[2];

    // overheat: assertion edge after two-stage synchroniser
    wire       hot_fall = hot_s3 & ~hot_s2;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            hot_s1 <= 1'b1;
            hot_s2 <= 1'b1;
            hot_s3 <= 1'b1;
        end else begin
            hot_s1 <= overheat_flag_in_n;
            hot_s2 <= hot_s1;
            hot_s3 <= hot_s2;
        end
    end

    // apb slave, one wait state
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~hit_any;
            prdata  <= (acc & hit_any & ~pwrite) ? {24'h00_0000, rd_all}
                                                 : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl1 <= RST_CTRL1;
            ctrl2 <= RST_CTRL2;
            cfg   <= RST_CFG;
        end else begin
            if (wr_en && hit_c1)
                ctrl1 <= pwdata[7:0];
            if (wr_en && hit_c2)
                ctrl2 <= pwdata[7:0];
            if (wr_en && hit_cfg)
                cfg   <= {6'h00, pwdata[1:0]};
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            // per-channel register decode
            wire [7:0] i_op = IDX_OP0 + 8'(ch);
            wire [7:0] i_lo = IDX_LO0 + 8'(2 * ch);
            wire [7:0] i_hi = IDX_HI0 + 8'(2 * ch);
            wire [7:0] i_fs = IDX_FS0 + 8'(ch);
            wire [7:0] i_hy = IDX_HY0 + 8'(ch);
            wire h_op = (idx == i_op);
            wire h_lo = (idx == i_lo);
            wire h_hi = (idx == i_hi);
            wire h_fs = (idx == i_fs);
            wire h_hy = (idx == i_hy);
            assign hit_ch[ch] = h_op | h_lo | h_hi | h_fs | h_hy;
            assign wr_op[ch]  = wr_en & h_op;
            assign wr_lo[ch]  = wr_en & h_lo;
            assign wr_hi[ch]  = wr_en & h_hi;
            assign wr_fs[ch]  = wr_en & h_fs;
            assign wr_hy[ch]  = wr_en & h_hy;
            assign rd_ch[ch]  = h_op ? op[ch] :
                                h_lo ? lo[ch] :
                                h_hi ? hi[ch] :
                                h_fs ? fs[ch] :
                                h_hy ? {3'b000, hy[ch]} : 8'h00;

            // cycle timing
            wire [11:0] n_short = SHORT_BASE << cyc_sel[ch];
            wire [11:0] n_long  = {n_short[10:0], 1'b0};
            wire [11:0] cnt_nx  = cnt[ch] + 12'h001;
            wire        wrap    = (cnt_nx == n_long);
            wire        short_h = monitor_done
                                  & ((cnt_nx == n_short) | wrap);
            wire        long_h  = monitor_done & wrap;

            // values in degrees, then in quarter degrees, signed
            wire signed [9:0]  op_d = deg(op[ch], ofs);
            wire signed [9:0]  lo_d = deg(lo[ch], ofs);
            wire signed [9:0]  hi_d = deg(hi[ch], ofs);
            wire signed [9:0]  fs_d = deg(fs[ch], ofs);
            wire signed [11:0] t_q  = {deg(temp[ch][9:2], ofs),
                                       temp[ch][1:0]};
            wire signed [11:0] p_q  = {deg(prev_t[ch][9:2], ofs),
                                       prev_t[ch][1:0]};
            wire signed [11:0] op_q = {op_d, 2'b00};
            wire signed [11:0] lo_q = {lo_d, 2'b00};
            wire signed [11:0] fs_q = {fs_d, 2'b00};
            wire signed [11:0] oh_q = op_q
                                      - $signed({5'b0_0000, hy[ch], 2'b00});
            wire signed [11:0] rise = t_q - p_q;

            wire below_fs = (t_q < fs_q);
            wire adapt    = ctrl1[CTRL1_ADP_LSB + ch] & ~below_fs;
            wire sh_dec   = short_h & (t_q > oh_q)
                            & (rise > SLOW_RISE_Q);
            wire lg_dec   = long_h & (t_q > op_q);
            wire lg_inc   = long_h & (t_q < lo_q) & (t_q > fs_q)
                            & (fs_d < hi_d) & (fs_d < op_d);
            wire signed [11:0] d_sh = sh_dec ? (rise >>> 1) : 12'sd0;
            wire signed [11:0] d_lg = lg_dec ? 12'sd1 : 12'sd0;
            wire signed [11:0] d_in = lg_inc ? 12'sd1 : 12'sd0;
            wire signed [11:0] sum  = {{2{fs_d[9]}}, fs_d}
                                      - d_sh - d_lg + d_in;
            wire signed [11:0] flr  = ofs ? FLOOR_OFS : FLOOR_TWOS;
            wire signed [11:0] clmp = (sum < flr) ? flr : sum;
            wire [11:0] raw_ofs     = clmp + 12'sd64;
            wire [7:0]  fs_new      = ofs ? raw_ofs[7:0] : clmp[7:0];
            wire        upd         = adapt & monitor_done;

            // applied value and its slew
            wire signed [9:0] out_d = deg(fs_out[ch], ofs);
            wire [7:0] slew = (out_d < fs_d) ? fs_out[ch] + 8'h01 :
                              (out_d > fs_d) ? fs_out[ch] - 8'h01 :
                              fs_out[ch];

            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    cnt[ch]    <= 12'h000;
                    prev_t[ch] <= 10'h000;
                end else if (monitor_done) begin
                    cnt[ch]    <= wrap ? 12'h000 : cnt_nx;
                    prev_t[ch] <= temp[ch];
                end
            end

            always_ff @(posedge mclk) begin
                if (!resetn)
                    op[ch] <= RST_OP;
                else if (hot_fall && ctrl1[CTRL1_CAP_LSB + ch])
                    op[ch] <= temp[ch][9:2];
                else if (wr_op[ch])
                    op[ch] <= pwdata[7:0];
            end

            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    lo[ch] <= RST_LO;
                    hi[ch] <= RST_HI;
                    hy[ch] <= RST_HY[HY_W-1:0];
                end else begin
                    if (wr_lo[ch])
                        lo[ch] <= pwdata[7:0];
                    if (wr_hi[ch])
                        hi[ch] <= pwdata[7:0];
                    if (wr_hy[ch])
                        hy[ch] <= pwdata[HY_W-1:0];
                end
            end

            always_ff @(posedge mclk) begin
                if (!resetn)
                    fs[ch] <= RST_FS;
                else if (upd && (sh_dec || lg_dec || lg_inc))
                    fs[ch] <= fs_new;
                else if (wr_fs[ch])
                    fs[ch] <= pwdata[7:0];
            end

            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    fs_out[ch]  <= RST_FS;
                    fan_off[ch] <= 1'b0;
                end else begin
                    fan_off[ch] <= below_fs;
                    if (!smooth)
                        fs_out[ch] <= fs[ch];
                    else if (monitor_done)
                        fs_out[ch] <= slew;
                end
            end
        end
    endgenerate

endmodule : aftl_top

// ---- testbench/aftl_assertions.sv ----
`timescale 1ns/1ns
module aftl_assertions
    import aftl_pkg::*;
(
    input wire logic                    mclk,
    input wire logic                    resetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [aftl_pkg::AW-1:0] paddr,
    input wire logic [aftl_pkg::DW-1:0] pwdata,
    input wire logic [aftl_pkg::DW-1:0] prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic [9:0]              temp_remote_a,
    input wire logic [9:0]              temp_local,
    input wire logic [9:0]              temp_remote_b,
    input wire logic                    monitor_done,
    input wire logic                    overheat_flag_in_n,
    input wire logic [7:0]              fan_start_remote_a,
    input wire logic [7:0]              fan_start_local,
    input wire logic [7:0]              fan_start_remote_b,
    input wire logic [2:0]              fan_off
);
    logic [2:0] upd_q;
    logic       wr_ok;
    assign wr_ok = psel & penable & pready & pwrite;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            upd_q <= 3'h0;
        end else begin
            upd_q <= {upd_q[1:0], monitor_done | wr_ok};
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_after_access_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after access phase");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error response without ready");
    misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    rdata_quiet_a: assert property (!(pready && !pwrite) |-> prdata == '0)
        else $error("read data outside a read answer");
    start_cause_a: assert property ($changed({fan_start_remote_a,
        fan_start_local, fan_start_remote_b}) |-> |upd_q)
        else $error("fan start moved without an update");
    start_floor_a: assert property (fan_start_remote_a != 8'h80 &&
        fan_start_local != 8'h80 && fan_start_remote_b != 8'h80)
        else $error("fan start below the floor");
    cover property (monitor_done && fan_off == 3'h0);
    cover property (pslverr);
    cover property (!overheat_flag_in_n);
    cover property (fan_off[0]);
endmodule : aftl_assertions

// ---- testbench/aftl_tb_top.sv ----
`timescale 1ns/1ns
module aftl_tb_top;
    import aftl_pkg::*;
    logic        mclk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [9:0]  ta;
    logic [9:0]  tl;
    logic [9:0]  tb;
    logic        monitor_done;
    logic        hot_n;
    logic [7:0]  fs_a;
    logic [7:0]  fs_l;
    logic [7:0]  fs_b;
    logic [2:0]  fan_off;
    int          n_errors;
    int          num_checks;
    aftl_top DUT (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .temp_remote_a(ta), .temp_local(tl), .temp_remote_b(tb),
        .monitor_done(monitor_done), .overheat_flag_in_n(hot_n),
        .fan_start_remote_a(fs_a), .fan_start_local(fs_l),
        .fan_start_remote_b(fs_b), .fan_off(fan_off));
    task end_sim;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [9:0] a, input logic [7:0] d,
             output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            end_sim();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, {idx, 2'b00}, d, r, e);
    endtask : wr
    task rdchk(input logic [9:0] a, input logic [7:0] exp, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        chk(40'({e, r}), 40'({ee, 24'h0, exp}));
    endtask : rdchk
    task rst;
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
    endtask : rst
    task md(input logic [7:0] deg, input logic [1:0] fr, input int n);
        ta <= {deg, fr};
        tl <= {deg, fr};
        tb <= {deg, fr};
        repeat (n) begin
            monitor_done <= 1'b1;
            @(posedge mclk);
            monitor_done <= 1'b0;
            @(posedge mclk);
        end
        @(posedge mclk);
    endtask : md
    task t_regs;
        rst();
        for (int i = 0; i < 3; i++) begin
            rdchk({IDX_OP0 + 8'(i), 2'b00}, RST_OP, 1'b0);
            rdchk({IDX_LO0 + 8'(2 * i), 2'b00}, RST_LO, 1'b0);
            rdchk({IDX_HI0 + 8'(2 * i), 2'b00}, RST_HI, 1'b0);
        end
        rdchk({IDX_CTRL1, 2'b00}, RST_CTRL1, 1'b0);
        wr(IDX_CTRL1, 8'ha5);
        rdchk({IDX_CTRL1, 2'b00}, 8'ha5, 1'b0);
        rdchk(10'h040, 8'h00, 1'b1);
        rdchk({IDX_OP0, 2'b01}, 8'h00, 1'b1);
        $display("register test done");
    endtask : t_regs
    task t_enable;
        logic [23:0] exp;
        for (int c = 0; c < 3; c++) begin
            rst();
            for (int i = 0; i < 3; i++) wr(IDX_OP0 + 8'(i), 8'h32);
            wr(IDX_CTRL1, 8'h20 << c);
            md(8'd100, 2'd0, 16);
            exp = {c == 0 ? 8'h59 : 8'h5a, c == 1 ? 8'h59 : 8'h5a,
                   c == 2 ? 8'h59 : 8'h5a};
            chk(40'({fs_a, fs_l, fs_b}), 40'(exp));
        end
        $display("enable test done");
    endtask : t_enable
    task t_reduce;
        rst();
        wr(IDX_OP0, 8'h32);
        wr(IDX_FS0, 8'h28);
        wr(IDX_CTRL1, 8'h20);
        md(8'd44, 2'd0, 7);
        md(8'd45, 2'd0, 1);
        chk(40'(fs_a), 40'h28);
        md(8'd48, 2'd0, 7);
        md(8'd49, 2'd0, 1);
        chk(40'(fs_a), 40'h26);
        md(8'd49, 2'd0, 7);
        md(8'd49, 2'd1, 1);
        chk(40'(fs_a), 40'h26);
        md(8'd52, 2'd0, 8);
        chk(40'(fs_a), 40'h25);
        md(8'd49, 2'd0, 16);
        chk(40'(fs_a), 40'h25);
        $display("reduce test done");
    endtask : t_reduce
    task t_raise;
        rst();
        wr(IDX_OP0, 8'h32);
        wr(IDX_FS0, 8'h1e);
        wr(IDX_LO0, 8'h28);
        wr(IDX_CTRL1, 8'h20);
        md(8'd45, 2'd0, 16);
        chk(40'(fs_a), 40'h1e);
        md(8'd20, 2'd0, 16);
        chk(40'({fan_off[0], fs_a}), 40'h11e);
        wr(IDX_HI0, 8'h1f);
        md(8'd35, 2'd0, 32);
        chk(40'({fan_off[0], fs_a}), 40'h01f);
        $display("raise test done");
    endtask : t_raise
    task t_cap;
        logic [2:0] m;
        rst();
        ta <= {8'h33, 2'b00};
        tl <= {8'h44, 2'b00};
        tb <= {8'h55, 2'b00};
        for (int k = 0; k < 2; k++) begin
            m = (k == 0) ? 3'b101 : 3'b010;
            for (int i = 0; i < 3; i++) wr(IDX_OP0 + 8'(i), 8'h11);
            wr(IDX_CTRL1, {3'b000, m, 2'b00});
            hot_n <= 1'b0;
            repeat (6) @(posedge mclk);
            rdchk({IDX_OP0 + 8'h2, 2'b00}, m[2] ? 8'h55 : 8'h11, 1'b0);
            wr(IDX_OP0 + 8'h2, 8'h22);
            hot_n <= 1'b1;
            repeat (4) @(posedge mclk);
            rdchk({IDX_OP0, 2'b00}, m[0] ? 8'h33 : 8'h11, 1'b0);
            rdchk({IDX_OP0 + 8'h1, 2'b00}, m[1] ? 8'h44 : 8'h11, 1'b0);
            rdchk({IDX_OP0 + 8'h2, 2'b00}, 8'h22, 1'b0);
        end
        $display("capture test done");
    endtask : t_cap
    task t_floor;
        rst();
        wr(IDX_OP0, 8'h80);
        wr(IDX_FS0, 8'h82);
        wr(IDX_CTRL2, 8'h01);
        wr(IDX_CTRL1, 8'h20);
        md(8'h85, 2'd0, 31);
        chk(40'(fs_a), 40'h82);
        md(8'h85, 2'd0, 1);
        chk(40'(fs_a), 40'h81);
        md(8'h85, 2'd0, 64);
        chk(40'(fs_a), 40'h81);
        wr(IDX_CTRL1, 8'h00);
        wr(IDX_CFG, 8'h02);
        wr(IDX_FS0, 8'h84);
        md(8'h85, 2'd0, 1);
        chk(40'(fs_a), 40'h82);
        $display("floor test done");
    endtask : t_floor
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        n_errors = 0;
        num_checks = 0;
        {resetn, psel, penable, pwrite, monitor_done} = 5'h0;
        hot_n = 1'b1;
        paddr = 10'h000;
        pwdata = 32'h0;
        {ta, tl, tb} = 30'h0;
        t_regs();
        t_enable();
        t_reduce();
        t_raise();
        t_cap();
        t_floor();
        end_sim();
    end
    initial begin
        #1000000;
        n_errors++;
        end_sim();
    end
endmodule : aftl_tb_top
bind aftl_top aftl_assertions u_chk (.mclk(mclk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .temp_remote_a(temp_remote_a), .temp_local(temp_local),
    .temp_remote_b(temp_remote_b), .monitor_done(monitor_done),
    .overheat_flag_in_n(overheat_flag_in_n),
    .fan_start_remote_a(fan_start_remote_a),
    .fan_start_local(fan_start_local),
    .fan_start_remote_b(fan_start_remote_b), .fan_off(fan_off));
